/* File: rtl/flash_regs_pkg.sv */
// constants and types for the flag, status and segment register bank
package flash_regs_pkg;
  // timing
  localparam int CLK_MHZ      = 50;
  localparam int WRITE_NS     = 1000;
  localparam int WRITE_CYC    = (WRITE_NS * CLK_MHZ + 999) / 1000;
  localparam int BUSY_W       = 8;

  // serial opcodes
  localparam logic [7:0] OP_WREN   = 8'h06;
  localparam logic [7:0] OP_WRDI   = 8'h04;
  localparam logic [7:0] OP_WRSR   = 8'h01;
  localparam logic [7:0] OP_RDSR   = 8'h05;
  localparam logic [7:0] OP_RDFLAG = 8'h70;
  localparam logic [7:0] OP_WRSEG  = 8'hc5;
  localparam logic [7:0] OP_RDSEG  = 8'hc8;
  localparam logic [7:0] OP_EN4B   = 8'hb7;
  localparam logic [7:0] OP_EX4B   = 8'he9;
  localparam logic [7:0] OP_SUSP   = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_RSTEN  = 8'h66;
  localparam logic [7:0] OP_RST    = 8'h99;
  localparam logic [7:0] OP_WRNV   = 8'hb1;
  localparam logic [7:0] OP_WRVOL  = 8'h81;

  // flag status bit positions
  localparam int FS_READY  = 7;
  localparam int FS_ESUSP  = 6;
  localparam int FS_EFAIL  = 5;
  localparam int FS_PFAIL  = 4;
  localparam int FS_PSUSP  = 2;
  localparam int FS_PROT   = 1;
  localparam int FS_ADDR   = 0;

  // status register: lock bit, block protect field, latch, in-progress
  localparam int SR_LOCK   = 7;
  localparam int SR_WEL    = 1;
  localparam int SR_WIP    = 0;
  localparam logic [7:0] SR_RESET = 8'h00;

  // configuration bytes
  localparam int          CFG_BYTES     = 8;
  localparam logic [2:0]  CFG_OTP_BYTE  = 3'h2;
  localparam int          CFG_LOCKHI    = 4;
  localparam logic [2:0]  CFG_ADDR_BYTE = 3'h5;
  localparam logic [7:0]  CFG_FOUR_BYTE = 8'hfe;
  localparam logic [7:0]  CFG_ERASED    = 8'hff;
  localparam logic [7:0]  SEG_RESET     = 8'h00;
  localparam logic [2:0]  ADDR3_LEFT    = 3'h2;
  localparam logic [2:0]  ADDR4_LEFT    = 3'h3;

  typedef enum logic [1:0] {
    X_IDLE = 2'b00,
    X_OPC  = 2'b01,
    X_ADDR = 2'b11,
    X_DATA = 2'b10
  } xfer_t;

  typedef enum logic [1:0] {
    AM_RANDOM = 2'b00,
    AM_CONT   = 2'b01,
    AM_PROG   = 2'b10,
    AM_CHIP   = 2'b11
  } amode_t;

  typedef struct packed {
    logic busy;
    logic prog_active;
    logic erase_active;
  } array_stat_t;

  typedef struct packed {
    logic prog_fail;
    logic erase_fail;
    logic prog_prot;
    logic erase_prot;
  } array_evt_t;

  typedef struct packed {
    logic        load;
    logic        incr;
    amode_t      mode;
    logic [31:0] addr;
  } addr_req_t;

  typedef struct packed {
    logic [2:0]            sck_sy;
    logic [2:0]            cs_n_sy;
    logic [1:0]            mosi_sy;
    logic [1:0]            wp_n_sy;
    xfer_t                 xfer;
    logic [2:0]            bit_cnt;
    logic [7:0]            rx;
    logic [7:0]            opcode;
    logic [2:0]            addr_left;
    logic [2:0]            cfg_idx;
    logic                  cfg_ok;
    logic [7:0]            tx;
    logic                  tx_en;
    logic                  miso;
    logic [7:0]            status;
    logic [CFG_BYTES-1:0][7:0] nv_cfg;
    logic [CFG_BYTES-1:0][7:0] work_cfg;
    logic                  four_byte;
    logic [7:0]            seg;
    logic                  ready;
    logic                  erase_susp;
    logic                  erase_fail;
    logic                  prog_fail;
    logic                  prog_susp;
    logic                  prot_fail;
    logic                  rst_armed;
    logic [BUSY_W-1:0]     busy_cnt;
    logic [25:0]           arr_addr;
  } state_t;
endpackage

/* File: rtl/flash_flag_and_ext_addr_regs.sv */
// flag status, status protection, segment select and working configuration of a serial flash
//
// Summary of operation
// R1: lock low, WP low: status writes rejected
// R2: lock low, WP high: write needs latch
// R3: both lock bits set: status never writable
// R4: eight-bit read-only flag register, fixed bit layout
// R5: address flag 0 for 3-byte, 1 for 4-byte
// R6: protected sector or locked OTP sets protection flag
// R7: resume clears protection flag
// R8: suspend sets erase or program suspended flag
// R9: resume, soft reset, power cycle clear suspends
// R10: program failure or protection sets program flag
// R11: erase failure or protection sets erase flag
// R12: busy during status, config, program, erase
// R13: ready flag high when idle, low busy
// R14: segment register bits 1:0, reset zero
// R15: segment bits select 16 MB in 3-byte
// R16: host loads segment with C5H plus byte
// R17: continuous read carries into next segment
// R18: chip erase covers entire array
// R19: program and erase stay inside segment
// R20: 4-byte mode ignores segment bits
// R21: reset copies nonvolatile into working config
// R22: volatile write replaces working config at once
`timescale 1ns/10ps
module flash_flag_and_ext_addr_regs
  import flash_regs_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_sck,
  input  wire logic        i_cs_n,
  input  wire logic        i_mosi,
  input  wire logic        i_wp_n,
  output logic             o_miso,
  output logic             o_miso_oe,
  input  wire array_stat_t i_arr,
  input  wire array_evt_t  i_evt,
  input  wire addr_req_t   i_areq,
  output logic [25:0]      o_array_addr,
  output logic [7:0]       o_flag_status,
  output logic [7:0]       o_segment,
  output logic             o_four_byte
);

  state_t     q;
  state_t     d;
  logic       sck_rise;
  logic       sck_fall;
  logic       selected;
  logic       cs_fall;
  logic       byte_done;
  logic [7:0] rx_byte;
  logic       lock_high;
  logic       sr_allowed;
  logic [7:0] flag_vec;
  logic [7:0] status_vec;

  // edges are seen only on the second and third sync stages
  assign sck_rise  = q.sck_sy[1] & ~q.sck_sy[2];
  assign sck_fall  = ~q.sck_sy[1] & q.sck_sy[2];
  assign selected  = ~q.cs_n_sy[1];
  assign cs_fall   = ~q.cs_n_sy[1] & q.cs_n_sy[2];
  assign rx_byte   = {q.rx[6:0], q.mosi_sy[1]};
  assign byte_done = selected && sck_rise && (q.bit_cnt == 3'h7) && (q.xfer != X_IDLE);
  assign lock_high = q.work_cfg[CFG_OTP_BYTE][CFG_LOCKHI];

  // R1 hardware lock
  // R2 latch gate
  // R3 permanent lock
  assign sr_allowed = q.status[SR_WEL] && !(q.status[SR_LOCK] && lock_high)
                      && !(q.status[SR_LOCK] && !q.wp_n_sy[1]);

  // R4 flag layout
  always_comb begin
    flag_vec           = 8'h00;
    // R13 ready high
    flag_vec[FS_READY] = q.ready;
    flag_vec[FS_ESUSP] = q.erase_susp;
    flag_vec[FS_EFAIL] = q.erase_fail;
    flag_vec[FS_PFAIL] = q.prog_fail;
    flag_vec[FS_PSUSP] = q.prog_susp;
    flag_vec[FS_PROT]  = q.prot_fail;
    // R5 address width
    flag_vec[FS_ADDR]  = q.four_byte;
  end

  always_comb begin
    status_vec         = q.status;
    status_vec[SR_WIP] = ~q.ready;
  end

  always_comb begin
    d         = q;
    d.sck_sy  = {q.sck_sy[1:0], i_sck};
    d.cs_n_sy = {q.cs_n_sy[1:0], i_cs_n};
    d.mosi_sy = {q.mosi_sy[0], i_mosi};
    d.wp_n_sy = {q.wp_n_sy[0], i_wp_n};

    if (!selected) begin
      d.xfer    = X_IDLE;
      d.bit_cnt = 3'h0;
      d.tx_en   = 1'b0;
    end else begin
      if (cs_fall) begin
        d.xfer    = X_OPC;
        d.bit_cnt = 3'h0;
      end
      if (sck_rise && q.xfer != X_IDLE) begin
        d.rx      = rx_byte;
        d.bit_cnt = q.bit_cnt + 3'h1;
      end
      // read data rotates so that the value repeats while clocked
      if (sck_fall && q.tx_en) begin
        d.miso = q.tx[7];
        d.tx   = {q.tx[6:0], q.tx[7]};
      end
    end

    if (q.busy_cnt != '0) begin
      d.busy_cnt = q.busy_cnt - BUSY_W'(1);
    end

    if (byte_done) begin
      case (q.xfer)
        X_OPC: begin
          d.opcode    = rx_byte;
          d.rst_armed = (rx_byte == OP_RSTEN);
          d.xfer      = X_IDLE;
          case (rx_byte)
            OP_WREN: d.status[SR_WEL] = 1'b1;
            OP_WRDI: d.status[SR_WEL] = 1'b0;
            // R20 enter 4-byte
            OP_EN4B: d.four_byte = 1'b1;
            OP_EX4B: d.four_byte = 1'b0;
            // R8 suspend flags
            OP_SUSP: begin
              if (i_arr.erase_active) begin
                d.erase_susp = 1'b1;
              end else if (i_arr.prog_active) begin
                d.prog_susp = 1'b1;
              end
            end
            OP_RESUME: begin
              // R10 program resume
              if (q.prog_susp) begin
                d.prog_fail = 1'b0;
              end
              // R11 erase resume
              if (q.erase_susp) begin
                d.erase_fail = 1'b0;
              end
              // R7 clear protection
              d.prot_fail  = 1'b0;
              // R9 resume clears
              d.erase_susp = 1'b0;
              d.prog_susp  = 1'b0;
            end
            OP_RST: begin
              if (q.rst_armed) begin
                // R9 soft reset clears
                d.erase_susp     = 1'b0;
                d.prog_susp      = 1'b0;
                d.status[SR_WEL] = 1'b0;
                // R14 segment reset
                d.seg            = SEG_RESET;
                // R21 reload working
                d.work_cfg       = q.nv_cfg;
                d.four_byte      = (q.nv_cfg[CFG_ADDR_BYTE] == CFG_FOUR_BYTE);
              end
            end
            OP_RDFLAG: begin
              d.tx    = flag_vec;
              d.tx_en = 1'b1;
            end
            OP_RDSR: begin
              d.tx    = status_vec;
              d.tx_en = 1'b1;
            end
            OP_RDSEG: begin
              d.tx    = q.seg;
              d.tx_en = 1'b1;
            end
            // R16 segment load
            OP_WRSR, OP_WRSEG: d.xfer = X_DATA;
            OP_WRNV, OP_WRVOL: begin
              d.xfer      = X_ADDR;
              d.addr_left = q.four_byte ? ADDR4_LEFT : ADDR3_LEFT;
            end
            default: d.xfer = X_IDLE;
          endcase
        end
        X_ADDR: begin
          // only the last address byte picks the configuration byte
          if (q.addr_left == 3'h0) begin
            d.cfg_idx = rx_byte[2:0];
            d.cfg_ok  = (rx_byte[7:3] == 5'h00);
            d.xfer    = X_DATA;
          end else begin
            d.addr_left = q.addr_left - 3'h1;
          end
        end
        X_DATA: begin
          d.xfer = X_IDLE;
          case (q.opcode)
            OP_WRSR: begin
              if (sr_allowed && q.ready) begin
                d.status[7:2]    = rx_byte[7:2];
                d.status[SR_WEL] = 1'b0;
                d.busy_cnt       = BUSY_W'(WRITE_CYC);
              end
            end
            // R14 writable bits
            OP_WRSEG: d.seg = {6'h00, rx_byte[1:0]};
            OP_WRNV: begin
              if (q.status[SR_WEL] && q.ready) begin
                d.nv_cfg[q.cfg_idx] = q.cfg_ok ? rx_byte : CFG_ERASED;
                d.status[SR_WEL]    = 1'b0;
                d.busy_cnt          = BUSY_W'(WRITE_CYC);
              end
            end
            OP_WRVOL: begin
              // R22 immediate update
              d.work_cfg[q.cfg_idx] = q.cfg_ok ? rx_byte : CFG_ERASED;
              if (q.cfg_idx == CFG_ADDR_BYTE) begin
                d.four_byte = q.cfg_ok && (rx_byte == CFG_FOUR_BYTE);
              end
            end
            default: d.xfer = X_IDLE;
          endcase
        end
        default: d.xfer = X_IDLE;
      endcase
    end

    // array events come last so that a set beats a same-cycle clear
    // R10 program error
    if (i_evt.prog_fail || i_evt.prog_prot) begin
      d.prog_fail = 1'b1;
    end
    // R11 erase error
    if (i_evt.erase_fail || i_evt.erase_prot) begin
      d.erase_fail = 1'b1;
    end
    // R6 protection error
    if (i_evt.prog_prot || i_evt.erase_prot) begin
      d.prot_fail = 1'b1;
    end

    // R12 busy sources
    d.ready = !(i_arr.busy || (d.busy_cnt != '0));

    if (i_areq.load) begin
      case (i_areq.mode)
        // R18 whole array
        AM_CHIP: d.arr_addr = 26'h0;
        default: begin
          // R15 segment select
          // R20 ignore segment
          d.arr_addr = q.four_byte ? i_areq.addr[25:0] : {q.seg[1:0], i_areq.addr[23:0]};
        end
      endcase
    end else if (i_areq.incr) begin
      if (q.four_byte || i_areq.mode == AM_CONT || i_areq.mode == AM_CHIP) begin
        // R17 carry into next
        d.arr_addr = q.arr_addr + 26'h1;
      end else begin
        // R19 wrap inside segment
        d.arr_addr = {q.arr_addr[25:24], q.arr_addr[23:0] + 24'h1};
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q          <= '0;
      q.sck_sy   <= 3'h0;
      q.cs_n_sy  <= 3'h7;
      q.xfer     <= X_IDLE;
      q.status   <= SR_RESET;
      q.nv_cfg   <= {CFG_BYTES{CFG_ERASED}};
      q.work_cfg <= {CFG_BYTES{CFG_ERASED}};
      q.seg      <= SEG_RESET;
      q.ready    <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign o_miso        = q.miso;
  assign o_miso_oe     = q.tx_en;
  assign o_array_addr  = q.arr_addr;
  assign o_flag_status = flag_vec;
  assign o_segment     = q.seg;
  assign o_four_byte   = q.four_byte;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_op(logic [7:0] op);
    byte_done && (q.xfer == X_OPC) && (rx_byte == op);
  endsequence

  sr_hw_lock_a: assert property (q.status[SR_LOCK] && !lock_high && !q.wp_n_sy[1]
    |=> $stable(q.status[7:2])) else $error("status changed under pin lock"); // R1
  sr_wel_gate_a: assert property (!q.status[SR_WEL]
    |=> $stable(q.status[7:2])) else $error("status changed without latch"); // R2
  sr_otp_lock_a: assert property (q.status[SR_LOCK] && lock_high
    |=> $stable(q.status[7:2])) else $error("status changed when locked"); // R3
  addr_mode_a: assert property (s_op(OP_EN4B)
    |=> o_flag_status[FS_ADDR] ##1 o_four_byte) else $error("4-byte flag not set"); // R5
  suspend_set_a: assert property (s_op(OP_SUSP) ##0 i_arr.erase_active
    |=> o_flag_status[FS_ESUSP]) else $error("erase suspend flag missing"); // R8
  resume_clr_a: assert property (s_op(OP_RESUME)
    |=> !q.erase_susp && !q.prog_susp) else $error("suspend flags not cleared"); // R9
  prot_clr_a: assert property (s_op(OP_RESUME) ##0 (!i_evt.prog_prot && !i_evt.erase_prot)
    |=> !o_flag_status[FS_PROT]) else $error("protection flag not cleared"); // R7
  busy_show_a: assert property (i_arr.busy
    |=> !o_flag_status[FS_READY]) else $error("busy not shown"); // R12
  seg_resv_a: assert property (o_segment[7:2] == 6'h00)
    else $error("segment reserved bits set"); // R14
  seg_bound_a: assert property (i_areq.incr && !i_areq.load && i_areq.mode == AM_PROG
    && !q.four_byte |=> $stable(o_array_addr[25:24])) else $error("segment crossed"); // R19

  // array event, program suspend and address mapping checks
  pfail_set_a: assert property (i_evt.prog_fail
    |=> o_flag_status[FS_PFAIL]) else $error("program error not set"); // R10
  efail_set_a: assert property (i_evt.erase_fail
    |=> o_flag_status[FS_EFAIL]) else $error("erase error not set"); // R11
  prot_set_a: assert property (i_evt.prog_prot || i_evt.erase_prot
    |=> o_flag_status[FS_PROT]) else $error("protection error not set"); // R6
  psusp_set_a: assert property (s_op(OP_SUSP) ##0 (!i_arr.erase_active && i_arr.prog_active)
    |=> o_flag_status[FS_PSUSP]) else $error("program suspend flag missing"); // R8
  chip_addr_a: assert property (i_areq.load && i_areq.mode == AM_CHIP
    |=> o_array_addr == 26'h0) else $error("chip erase address not zero"); // R18
  seg_map_a: assert property (i_areq.load && i_areq.mode != AM_CHIP && !q.four_byte
    |=> o_array_addr[25:24] == $past(q.seg[1:0])) else $error("segment not applied"); // R15
  four_map_a: assert property (i_areq.load && i_areq.mode != AM_CHIP && q.four_byte
    |=> o_array_addr == $past(i_areq.addr[25:0])) else $error("segment not ignored"); // R20

endmodule

/* File: tb/flash_host_model.sv */
// serial host controller model driving the flash register bank pins
`timescale 1ns/10ps
module flash_host_model (
  input  wire logic i_sys_clk,
  input  wire logic i_miso,
  input  wire logic i_miso_oe,
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_mosi
);
  logic last_q;
  logic miso_w;

  // no pull on the data out line: when released the model sees the inverse level
  assign miso_w = i_miso_oe ? i_miso : ~last_q;

  initial begin
    o_sck  = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
    last_q = 1'b0;
  end

  // half of a 160 ns serial period
  task automatic half();
    repeat (4) @(negedge i_sys_clk);
  endtask

  task automatic start();
    o_cs_n = 1'b0;
    half();
  endtask

  // mode 0, msb first; read bits are taken at the end of the high phase
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      o_sck  = 1'b0;
      o_mosi = tx[i];
      half();
      o_sck = 1'b1;
      half();
      rx[i]  = miso_w;
      last_q = miso_w;
    end
  endtask

  // clock parks low between frames; the gap covers the input synchronisers
  task automatic stop();
    o_sck = 1'b0;
    half();
    o_cs_n = 1'b1;
    repeat (8) @(negedge i_sys_clk);
  endtask
endmodule

/* File: tb/flash_flag_and_ext_addr_regs_bench.sv */
// self-checking bench for the flag, status and segment register bank
`timescale 1ns/10ps
module flash_flag_and_ext_addr_regs_bench;
  import flash_regs_pkg::*;

  logic        i_sys_clk;
  logic        i_rstn;
  logic        i_wp_n;
  logic        sck;
  logic        cs_n;
  logic        mosi;
  logic        o_miso;
  logic        o_miso_oe;
  array_stat_t i_arr;
  array_evt_t  i_evt;
  addr_req_t   i_areq;
  logic [25:0] o_array_addr;
  logic [7:0]  o_flag_status;
  logic [7:0]  o_segment;
  logic        o_four_byte;
  logic [7:0]  v;
  int          errors;
  int          n_tests;

  flash_flag_and_ext_addr_regs dut (
    .i_sys_clk     (i_sys_clk),
    .i_rstn        (i_rstn),
    .i_sck         (sck),
    .i_cs_n        (cs_n),
    .i_mosi        (mosi),
    .i_wp_n        (i_wp_n),
    .o_miso        (o_miso),
    .o_miso_oe     (o_miso_oe),
    .i_arr         (i_arr),
    .i_evt         (i_evt),
    .i_areq        (i_areq),
    .o_array_addr  (o_array_addr),
    .o_flag_status (o_flag_status),
    .o_segment     (o_segment),
    .o_four_byte   (o_four_byte)
  );

  flash_host_model host (
    .i_sys_clk (i_sys_clk),
    .i_miso    (o_miso),
    .i_miso_oe (o_miso_oe),
    .o_sck     (sck),
    .o_cs_n    (cs_n),
    .o_mosi    (mosi)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [25:0] exp, input logic [25:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic pwr();
    i_rstn = 1'b0;
    repeat (20) @(negedge i_sys_clk);
    i_rstn = 1'b1;
    repeat (5) @(negedge i_sys_clk);
  endtask

  task automatic cmd(input logic [7:0] op);
    logic [7:0] rx;
    host.start();
    host.xbyte(op, rx);
    host.stop();
  endtask

  task automatic cmd1(input logic [7:0] op, input logic [7:0] d);
    logic [7:0] rx;
    host.start();
    host.xbyte(op, rx);
    host.xbyte(d, rx);
    host.stop();
  endtask

  task automatic rd(input logic [7:0] op, output logic [7:0] d);
    logic [7:0] rx;
    host.start();
    host.xbyte(op, rx);
    host.xbyte(8'h00, d);
    host.stop();
  endtask

  // configuration write: three address bytes, the last selects the byte
  task automatic cfg(input logic [7:0] op, input logic [2:0] idx, input logic [7:0] d);
    logic [7:0] rx;
    host.start();
    host.xbyte(op, rx);
    host.xbyte(8'h00, rx);
    host.xbyte(8'h00, rx);
    host.xbyte({5'h00, idx}, rx);
    host.xbyte(d, rx);
    host.stop();
  endtask

  task automatic wait_ready();
    int k;
    k = 0;
    while (o_flag_status[FS_READY] !== 1'b1 && k < 200) begin
      @(negedge i_sys_clk);
      k++;
    end
    if (o_flag_status[FS_READY] !== 1'b1) begin
      errors++;
      $display("[ERR] ready expected 1 seen %b", o_flag_status[FS_READY]);
      tally_and_finish();
    end
  endtask

  // an accepted status write shows busy right after the frame
  task automatic wrsr(input logic [7:0] d, input logic acc);
    cmd1(OP_WRSR, d);
    chk("ready after write", !acc, o_flag_status[FS_READY]);
    wait_ready();
  endtask

  task automatic areq(input logic ld, input amode_t m, input logic [31:0] a,
                      input logic [25:0] exp);
    @(negedge i_sys_clk);
    i_areq = '{load: ld, incr: !ld, mode: m, addr: a};
    @(negedge i_sys_clk);
    i_areq = '0;
    chk("array addr", exp, o_array_addr);
  endtask

  task automatic evt(input logic [3:0] e);
    @(negedge i_sys_clk);
    i_evt = array_evt_t'(e);
    @(negedge i_sys_clk);
    i_evt = '0;
    repeat (2) @(negedge i_sys_clk);
  endtask

  initial begin
    errors  = 0;
    n_tests = 0;
    i_rstn  = 1'b0;
    i_wp_n  = 1'b1;
    i_arr   = '0;
    i_evt   = '0;
    i_areq  = '0;
    pwr();
    chk("flag", 8'h80, o_flag_status);
    rd(OP_RDFLAG, v);
    chk("flag read", 8'h80, v);
    chk("segment", 8'h00, o_segment);
    $display("test reset done");
    cmd1(OP_WRSEG, 8'hff);
    rd(OP_RDSEG, v);
    chk("segment read", 8'h03, v);
    areq(1'b1, AM_RANDOM, 32'h00123456, 26'h3123456);
    areq(1'b1, AM_CHIP, 32'h00123456, 26'h0000000);
    areq(1'b1, AM_PROG, 32'h00ffffff, 26'h3ffffff);
    areq(1'b0, AM_PROG, 32'h00000000, 26'h3000000);
    cmd1(OP_WRSEG, 8'h01);
    areq(1'b1, AM_CONT, 32'h00ffffff, 26'h1ffffff);
    areq(1'b0, AM_CONT, 32'h00000000, 26'h2000000);
    chk("segment kept", 8'h01, o_segment);
    cmd(OP_EN4B);
    chk("flag", 8'h81, o_flag_status);
    areq(1'b1, AM_RANDOM, 32'h02abcdef, 26'h2abcdef);
    cmd(OP_EX4B);
    chk("flag", 8'h80, o_flag_status);
    $display("test segment done");
    cfg(OP_WRVOL, 3'h2, 8'hef);
    cmd(OP_WREN);
    wrsr(8'h80, 1'b1);
    rd(OP_RDSR, v);
    chk("status", 8'h80, v);
    i_wp_n = 1'b0;
    cmd(OP_WREN);
    wrsr(8'h00, 1'b0);
    rd(OP_RDSR, v);
    chk("status", 8'h82, v);
    i_wp_n = 1'b1;
    cmd(OP_WRDI);
    wrsr(8'h00, 1'b0);
    cmd(OP_WREN);
    wrsr(8'h80, 1'b1);
    cfg(OP_WRVOL, 3'h2, 8'hff);
    cmd(OP_WREN);
    wrsr(8'h00, 1'b0);
    rd(OP_RDSR, v);
    chk("status", 8'h82, v);
    $display("test protect done");
    i_arr = array_stat_t'(3'h1);
    cmd(OP_SUSP);
    chk("flag", 8'hc0, o_flag_status);
    evt(4'h1);
    chk("flag", 8'he2, o_flag_status);
    cmd(OP_RESUME);
    chk("flag", 8'h80, o_flag_status);
    i_arr = array_stat_t'(3'h2);
    cmd(OP_SUSP);
    evt(4'h8);
    chk("flag", 8'h94, o_flag_status);
    cmd(OP_RESUME);
    chk("flag", 8'h80, o_flag_status);
    cmd(OP_SUSP);
    cmd1(OP_WRSEG, 8'h02);
    cmd(OP_RSTEN);
    cmd(OP_RST);
    chk("program suspend", 1'b0, o_flag_status[FS_PSUSP]);
    chk("segment", 8'h00, o_segment);
    i_arr = array_stat_t'(3'h4);
    repeat (2) @(negedge i_sys_clk);
    chk("ready", 1'b0, o_flag_status[FS_READY]);
    i_arr = '0;
    $display("test flags done");
    cfg(OP_WRVOL, CFG_ADDR_BYTE, CFG_FOUR_BYTE);
    chk("four byte", 1'b1, o_four_byte);
    cmd(OP_RSTEN);
    cmd(OP_RST);
    chk("four byte", 1'b0, o_four_byte);
    cmd(OP_WREN);
    cfg(OP_WRNV, CFG_ADDR_BYTE, CFG_FOUR_BYTE);
    chk("ready", 1'b0, o_flag_status[FS_READY]);
    wait_ready();
    cmd(OP_RSTEN);
    cmd(OP_RST);
    chk("flag", 8'h81, o_flag_status);
    pwr();
    chk("flag", 8'h80, o_flag_status);
    $display("test config done");
    tally_and_finish();
  end
endmodule
